/* File: logic/rdc_pkg.sv */
// Purpose: Shared constants, types and register map of the redriver control block
// Assumes: mclk at 50 MHz; four-level straps arrive encoded as 2'b00=0, 01=R, 10=F, 11=1
// Notes:   Every offset, field position, reset value and timing count lives here
package rdc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int DB_MAX_MS = 16;
	// Longest time, so rounded down
	localparam int DB_CYCLES = DB_MAX_MS * CLK_PER_MS;
	localparam int RXDET_PERIOD_US = 50;
	localparam int RXDET_CYCLES = RXDET_PERIOD_US * CLK_PER_US;
	localparam int U1_IDLE_US = 10;
	localparam int U1_IDLE_CYCLES = U1_IDLE_US * CLK_PER_US;
	// Edges after power-good release before straps are taken (synchroniser depth)
	localparam int STRAP_SETTLE = 3;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CONTROL_MODE = 8'h0A;
	localparam logic [7:0] REG_CHANNEL_SWAP = 8'h0B;
	localparam logic [7:0] REG_GAIN_DIRECTION = 8'h0C;
	localparam logic [7:0] REG_UP_EQ_TWO = 8'h10;
	localparam logic [7:0] REG_UP_EQ_ONE = 8'h11;
	localparam logic [7:0] REG_SNOOPED = 8'h12;
	localparam logic [7:0] REG_AUX_LANE = 8'h13;
	localparam logic [7:0] REG_DISPLAY_FIVE = 8'h1B;
	localparam logic [7:0] REG_USB_ONE = 8'h20;
	localparam logic [7:0] REG_USB_TWO = 8'h21;
	localparam logic [7:0] REG_USB_THREE = 8'h22;
	localparam logic [7:0] REG_USB_FOUR = 8'h23;
	localparam int NUM_SLOTS = 11;
	localparam logic [7:0] CONTROL_MODE_RST = 8'h01;
	localparam logic [7:0] OTHER_RST = 8'h00;
	// Writable bit masks; reserved read-only bits stay zero
	localparam logic [7:0] MASK_CONTROL_MODE = 8'h7F;
	localparam logic [7:0] MASK_CHANNEL_SWAP = 8'h0F;
	localparam logic [7:0] MASK_GAIN_DIRECTION = 8'h7F;
	localparam logic [7:0] MASK_AUX_LANE = 8'hBF;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	// Field positions
	localparam int CONN_LSB = 0;
	localparam int ORIENT_BIT = 2;
	localparam int HOTPLUG_OVR_BIT = 3;
	localparam int EQ_OVR_BIT = 4;
	localparam int SWAP_BIT = 5;
	localparam int GAIN_SEL_LSB = 2;
	localparam int GAIN_OVR_BIT = 6;

	// ----------------------------------------------------------------
	// Bus target address groups, picked by the upper address strap
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_GROUP_0 = 7'h44;
	localparam logic [6:0] ADDR_GROUP_R = 7'h20;
	localparam logic [6:0] ADDR_GROUP_F = 7'h10;
	localparam logic [6:0] ADDR_GROUP_1 = 7'h0C;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LPM_DISCONNECT = 2'b00,
		LPM_U0 = 2'b01,
		LPM_U1 = 2'b10,
		LPM_U23 = 2'b11
	} rdc_lpm_e;

	typedef enum logic [3:0] {
		BUS_IDLE = 4'h0,
		BUS_ADDR = 4'h1,
		BUS_ADDR_ACK = 4'h2,
		BUS_INDEX = 4'h3,
		BUS_INDEX_ACK = 4'h4,
		BUS_WDATA = 4'h5,
		BUS_WDATA_ACK = 4'h6,
		BUS_RDATA = 4'h7,
		BUS_RDATA_ACK = 4'h8
	} rdc_bus_e;

	typedef struct packed {
		logic i2c_mode;
		logic [1:0] address_strap_hi;
		logic [1:0] address_strap_lo;
		logic [1:0] downstream_eq_straps;
		logic [1:0] output_config_strap_hi;
		logic [1:0] output_config_strap_lo;
	} rdc_strap_s;

	typedef struct packed {
		logic term_up;
		logic term_dn;
		logic idle_up;
		logic idle_dn;
		logic lfps;
	} rdc_phy_in_s;

	typedef struct packed {
		logic rx_term_en;
		logic tx_cm_en;
		logic redrive_en;
		logic rx_detect_en;
		logic los_lfps_det_en;
	} rdc_phy_ctl_s;

	typedef struct packed {
		logic usb_en;
		logic dp_en;
		logic dp_four_lane;
		logic orientation_select;
		logic swap;
		logic equalizer_override;
		logic hotplug_input_override;
	} rdc_mode_s;

endpackage

/* File: logic/rdc_redriver_ctl.sv */
// Purpose: Bus target, strap capture, pin debounce and USB link-power tracking of the redriver
// Assumes: rst is internal power-good (high while power is not good); scl_clk is the bus clock pin
// Notes:   Bus start/stop and edges are seen on mclk; data bits are captured on scl_clk
//
// Behaviour
// - Target address from two four-level address straps
// - Acknowledge matching address, index and data bytes
// - Further written bytes acknowledged until stop
// - Read starts at pointer, MSB first
// - Index write sets following read start
// - Next register sent only after controller acknowledge
// - Hardware-updated fields change; zero writes harmless
// - Control register resets 01h with listed fields
// - Connection select decodes to USB/DP enables
// - USB enabled means one of four states
// - Disconnect to U0 when both terminations seen
// - U0 redrives; both idle moves to U1
// - U1 keeps terminations and common mode
// - U2/U3 periodic detect; missing termination disconnects
// - U2/U3 valid LFPS moves straight to U0
// - Sleep low suspends detection, and LFPS monitoring in U2/U3
// - Sleep low holds Disconnect without detection
// - Straps sampled once at power-good release
// - Control and orientation pins debounced, bounded
// - Reserved output-config settings never applied
module rdc_redriver_ctl #(
	parameter int DB_CYCLES = rdc_pkg::DB_CYCLES,
	parameter int U1_IDLE_CYCLES = rdc_pkg::U1_IDLE_CYCLES,
	parameter int RXDET_CYCLES = rdc_pkg::RXDET_CYCLES
) (
	// Clocks and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl_clk,
	// Bus data pin, open drain
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Straps and control pins
	input rdc_pkg::rdc_strap_s strap_pins,
	input wire logic [1:0] connection_control_pins,
	input wire logic orientation_pin,
	input wire logic sleep_input_n,
	// Physical layer status and snooped link state
	input rdc_pkg::rdc_phy_in_s phy_status,
	input wire logic [6:0] snooped_state,
	// Results
	output rdc_pkg::rdc_phy_ctl_s phy_ctl,
	output rdc_pkg::rdc_mode_s mode,
	output rdc_pkg::rdc_lpm_e link_state,
	output logic [3:0] vod_dcgain_sel,
	output logic vod_cfg_reserved,
	output logic [6:0] target_address
);
	import rdc_pkg::*;

	localparam int SYNC_W = $bits(rdc_strap_s) + $bits(rdc_phy_in_s) + 6;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic [6:0] addr_from_straps(input logic [1:0] hi, input logic [1:0] lo);
		logic [6:0] base;
		base = ADDR_GROUP_0;
		case (hi)
			2'b00: base = ADDR_GROUP_0;
			2'b01: base = ADDR_GROUP_R;
			2'b10: base = ADDR_GROUP_F;
			default: base = ADDR_GROUP_1;
		endcase
		return base | {5'h00, lo};
	endfunction

	function automatic logic [3:0] slot_of(input logic [7:0] idx);
		case (idx)
			REG_CONTROL_MODE: return 4'h0;
			REG_CHANNEL_SWAP: return 4'h1;
			REG_GAIN_DIRECTION: return 4'h2;
			REG_UP_EQ_TWO: return 4'h3;
			REG_UP_EQ_ONE: return 4'h4;
			REG_AUX_LANE: return 4'h5;
			REG_DISPLAY_FIVE: return 4'h6;
			REG_USB_ONE: return 4'h7;
			REG_USB_TWO: return 4'h8;
			REG_USB_THREE: return 4'h9;
			REG_USB_FOUR: return 4'hA;
			default: return 4'hF;
		endcase
	endfunction

	function automatic logic [7:0] mask_of(input logic [7:0] idx);
		case (idx)
			REG_CONTROL_MODE: return MASK_CONTROL_MODE;
			REG_CHANNEL_SWAP: return MASK_CHANNEL_SWAP;
			REG_GAIN_DIRECTION: return MASK_GAIN_DIRECTION;
			REG_AUX_LANE: return MASK_AUX_LANE;
			default: return MASK_FULL;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] pin_raw, s1_q, s2_q, s3_q, flt_q, flt_d;
	logic scl_prev_q, sda_prev_q;

	assign pin_raw = {strap_pins, phy_status, sleep_input_n, orientation_pin,
		connection_control_pins, scl_clk, sda_i};
	// A bit only moves once stages two and three agree
	assign flt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);

	always_ff @(posedge mclk) begin
		s1_q <= pin_raw;
		s2_q <= s1_q;
		s3_q <= s2_q;
		if (rst) begin
			flt_q <= SYNC_W'(6'h23); // Idle levels: bus lines high, sleep high
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			flt_q <= flt_d;
			scl_prev_q <= flt_q[1];
			sda_prev_q <= flt_q[0];
		end
	end

	wire logic sda_f = flt_q[0];
	wire logic scl_f = flt_q[1];
	wire logic [1:0] conn_pins_f = flt_q[3:2];
	wire logic orient_pin_f = flt_q[4];
	wire logic sleep_n_f = flt_q[5];
	rdc_phy_in_s phy_f;
	rdc_strap_s strap_f;
	assign phy_f = flt_q[$bits(rdc_phy_in_s)+5:6];
	assign strap_f = flt_q[SYNC_W-1:$bits(rdc_phy_in_s)+6];

	// ----------------------------------------------------------------
	// Bus clock domain: data bit captured on each rising bus clock
	// ----------------------------------------------------------------
	// Stable for a whole bus clock period, so the mclk side reads it only
	// after its own synchronised view of the same rising edge.
	logic scl_bit_q;

	always_ff @(posedge scl_clk) begin
		scl_bit_q <= sda_i;
	end

	// ----------------------------------------------------------------
	// Bus events on mclk
	// ----------------------------------------------------------------
	wire logic bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	wire logic bus_stop = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
	wire logic scl_rise = scl_f & ~scl_prev_q;
	wire logic scl_fall = ~scl_f & scl_prev_q;

	// ----------------------------------------------------------------
	// Straps, taken once after power-good release
	// ----------------------------------------------------------------
	rdc_strap_s strap_q;
	logic [1:0] strap_cnt_q;
	logic strap_done_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			strap_q <= '0;
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == 2'(STRAP_SETTLE - 1)) begin
				strap_q <= strap_f;
				strap_done_q <= 1'b1;
			end
		end
	end

	wire logic [6:0] dev_addr = addr_from_straps(strap_q.address_strap_hi, strap_q.address_strap_lo);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] reg_q [NUM_SLOTS];
	logic [7:0] ptr_q, ptr_d, rd_byte;
	logic [7:0] shr_q, shr_d;
	logic reg_we;
	wire logic [3:0] wr_slot = slot_of(ptr_q);
	wire logic [7:0] wr_mask = mask_of(ptr_q);
	wire logic [7:0] ctrl_reg = reg_q[0];
	wire logic [7:0] gain_reg = reg_q[2];
	wire logic [3:0] cfg_strap_sel = {strap_q.output_config_strap_hi, strap_q.output_config_strap_lo};
	wire logic gain_ovr = gain_reg[GAIN_OVR_BIT];

	// Only mapped slots are stored; unmapped writes are acknowledged and dropped
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_q[0] <= CONTROL_MODE_RST;
			for (int i = 1; i < NUM_SLOTS; i++) begin
				reg_q[i] <= OTHER_RST;
			end
		end else if (reg_we && wr_slot != 4'hF) begin
			reg_q[wr_slot] <= (reg_q[wr_slot] & ~wr_mask) | (shr_q & wr_mask);
		end
	end

	// Read mux; hardware-updated fields read their live source
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_q == REG_SNOOPED) begin
			rd_byte = {1'b0, snooped_state};
		end else if (ptr_q == REG_GAIN_DIRECTION && !gain_ovr) begin
			rd_byte = {gain_reg[7:6], cfg_strap_sel, gain_reg[1:0]};
		end else if (slot_of(ptr_q) != 4'hF) begin
			rd_byte = reg_q[slot_of(ptr_q)];
		end
	end

	// ----------------------------------------------------------------
	// Bus target state machine
	// ----------------------------------------------------------------
	rdc_bus_e bst_q, bst_d;
	logic [3:0] bcnt_q, bcnt_d;
	logic oe_q, oe_d;
	wire logic [2:0] bit_idx = 3'(3'd7 - bcnt_q[2:0]);
	wire logic byte_done = (bcnt_q == 4'h8);

	always_comb begin
		bst_d = bst_q;
		bcnt_d = bcnt_q;
		shr_d = shr_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		reg_we = 1'b0;
		if (bus_start) begin
			bst_d = BUS_ADDR;
			bcnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (bus_stop) begin
			bst_d = BUS_IDLE;
			oe_d = 1'b0;
		end else if (scl_rise) begin
			case (bst_q)
				BUS_ADDR, BUS_INDEX, BUS_WDATA: begin
					shr_d = {shr_q[6:0], scl_bit_q};
					bcnt_d = bcnt_q + 4'h1;
				end
				BUS_RDATA: begin
					bcnt_d = bcnt_q + 4'h1;
				end
				BUS_RDATA_ACK: begin
					if (!scl_bit_q) begin
						shr_d = rd_byte;
						bcnt_d = 4'h0;
						bst_d = BUS_RDATA;
					end else begin
						bst_d = BUS_IDLE;
					end
				end
				default: begin
					bcnt_d = bcnt_q;
				end
			endcase
		end else if (scl_fall) begin
			case (bst_q)
				BUS_ADDR: begin
					if (byte_done) begin
						if (shr_q[7:1] == dev_addr) begin
							oe_d = 1'b1;
							bst_d = BUS_ADDR_ACK;
						end else begin
							bst_d = BUS_IDLE;
						end
					end
				end
				BUS_ADDR_ACK: begin
					bcnt_d = 4'h0;
					if (shr_q[0]) begin
						shr_d = rd_byte;
						oe_d = ~rd_byte[7];
						bst_d = BUS_RDATA;
					end else begin
						oe_d = 1'b0;
						bst_d = BUS_INDEX;
					end
				end
				BUS_INDEX: begin
					if (byte_done) begin
						ptr_d = shr_q;
						oe_d = 1'b1;
						bst_d = BUS_INDEX_ACK;
					end
				end
				BUS_WDATA: begin
					if (byte_done) begin
						reg_we = 1'b1;
						ptr_d = ptr_q + 8'h01;
						oe_d = 1'b1;
						bst_d = BUS_WDATA_ACK;
					end
				end
				BUS_INDEX_ACK, BUS_WDATA_ACK: begin
					oe_d = 1'b0;
					bcnt_d = 4'h0;
					bst_d = BUS_WDATA;
				end
				BUS_RDATA: begin
					if (byte_done) begin
						oe_d = 1'b0;
						ptr_d = ptr_q + 8'h01;
						bst_d = BUS_RDATA_ACK;
					end else begin
						oe_d = ~shr_q[bit_idx];
					end
				end
				default: begin
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bst_q <= BUS_IDLE;
			bcnt_q <= 4'h0;
			shr_q <= 8'h00;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			bst_q <= bst_d;
			bcnt_q <= bcnt_d;
			shr_q <= shr_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
		end
	end

	// Open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe = oe_q;
	assign target_address = dev_addr;

	// ----------------------------------------------------------------
	// Control and orientation pin debounce
	// ----------------------------------------------------------------
	logic [2:0] db_q;
	logic [23:0] db_cnt_q;
	wire logic [2:0] db_raw = {conn_pins_f, orient_pin_f};

	// A change is taken only after the pins have differed from the held value for the whole interval
	always_ff @(posedge mclk) begin
		if (rst) begin
			db_q <= 3'b010;
			db_cnt_q <= 24'h000000;
		end else if (db_raw == db_q) begin
			db_cnt_q <= 24'h000000;
		end else if (db_cnt_q == 24'(DB_CYCLES - 1)) begin
			db_q <= db_raw;
			db_cnt_q <= 24'h000000;
		end else begin
			db_cnt_q <= db_cnt_q + 24'h000001;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	wire logic [1:0] conn_sel = strap_q.i2c_mode ? ctrl_reg[CONN_LSB+1:CONN_LSB] : db_q[2:1];
	wire logic orient_sel = strap_q.i2c_mode ? ctrl_reg[ORIENT_BIT] : db_q[0];
	wire logic usb_on = conn_sel[0];
	wire logic [3:0] cfg_sel = gain_ovr ? gain_reg[GAIN_SEL_LSB+3:GAIN_SEL_LSB] : cfg_strap_sel;
	wire logic cfg_bad = cfg_sel[3]; // Upper strap at F or 1, or gain register bit 5 under gain override

	always_ff @(posedge mclk) begin
		if (rst) begin
			mode <= '0;
			vod_dcgain_sel <= 4'h0;
			vod_cfg_reserved <= 1'b0;
		end else begin
			mode.usb_en <= usb_on;
			mode.dp_en <= conn_sel[1];
			mode.dp_four_lane <= (conn_sel == 2'b10);
			mode.orientation_select <= orient_sel;
			mode.swap <= ctrl_reg[SWAP_BIT];
			mode.equalizer_override <= ctrl_reg[EQ_OVR_BIT];
			mode.hotplug_input_override <= ctrl_reg[HOTPLUG_OVR_BIT];
			vod_dcgain_sel <= cfg_bad ? 4'h0 : cfg_sel;
			vod_cfg_reserved <= cfg_bad;
		end
	end

	// ----------------------------------------------------------------
	// USB link-power tracker
	// ----------------------------------------------------------------
	rdc_lpm_e lpm_q, lpm_d;
	logic [15:0] idle_cnt_q, rxdet_cnt_q;
	wire logic both_term = phy_f.term_up & phy_f.term_dn;
	wire logic both_idle = phy_f.idle_up & phy_f.idle_dn;
	wire logic rxdet_tick = (rxdet_cnt_q == 16'(RXDET_CYCLES - 1));
	wire logic u1_timeout = (idle_cnt_q == 16'(U1_IDLE_CYCLES - 1));

	always_comb begin
		lpm_d = lpm_q;
		case (lpm_q)
			LPM_DISCONNECT: begin
				if (sleep_n_f && both_term) begin
					lpm_d = LPM_U0;
				end
			end
			LPM_U0: begin
				if (both_idle) begin
					lpm_d = LPM_U1;
				end
			end
			LPM_U1: begin
				if (!both_idle) begin
					lpm_d = LPM_U0;
				end else if (u1_timeout) begin
					lpm_d = LPM_U23;
				end
			end
			LPM_U23: begin
				if (sleep_n_f && rxdet_tick && !both_term) begin
					lpm_d = LPM_DISCONNECT;
				end else if (sleep_n_f && phy_f.lfps) begin
					lpm_d = LPM_U0;
				end
			end
			default: begin
				lpm_d = LPM_DISCONNECT;
			end
		endcase
		if (!usb_on) begin
			lpm_d = LPM_DISCONNECT;
		end
	end

	// Timers restart on every state change so each stay is measured alone
	always_ff @(posedge mclk) begin
		if (rst) begin
			lpm_q <= LPM_DISCONNECT;
			idle_cnt_q <= 16'h0000;
			rxdet_cnt_q <= 16'h0000;
		end else begin
			lpm_q <= lpm_d;
			idle_cnt_q <= (lpm_d == LPM_U1 && lpm_q == LPM_U1) ? idle_cnt_q + 16'h0001 : 16'h0000;
			if (lpm_q != LPM_U23 || !sleep_n_f || rxdet_tick) begin
				rxdet_cnt_q <= 16'h0000;
			end else begin
				rxdet_cnt_q <= rxdet_cnt_q + 16'h0001;
			end
		end
	end

	// Physical layer controls, registered from the next state
	always_ff @(posedge mclk) begin
		if (rst) begin
			phy_ctl <= '0;
		end else begin
			phy_ctl.rx_term_en <= (lpm_d != LPM_DISCONNECT);
			phy_ctl.tx_cm_en <= (lpm_d == LPM_U0) || (lpm_d == LPM_U1);
			phy_ctl.redrive_en <= (lpm_d == LPM_U0);
			phy_ctl.rx_detect_en <= usb_on && sleep_n_f && (lpm_d == LPM_DISCONNECT ||
				(lpm_d == LPM_U23 && rxdet_tick));
			phy_ctl.los_lfps_det_en <= (lpm_d != LPM_DISCONNECT) &&
				!(lpm_d == LPM_U23 && !sleep_n_f);
		end
	end

	assign link_state = lpm_q;

endmodule

/* File: testbench/rdc_i2c_host.sv */
// Purpose: Bus controller model driving the clock and open-drain data
// Assumes: 48 ns base clock; clock high phase lasts five base periods, low phase seven
// Notes: Clock stands high between frames; data moves while clock is high only for start and stop
module rdc_i2c_host (
	// Bus pins
	output logic scl,
	output logic sda_oe,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lk = 1'b0;

	always #24 lk = ~lk;

	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	task automatic tick();
		repeat (5) @(posedge lk);
	endtask

	// One bit; data held two base periods past the fall so it never races a start
	task automatic bit_io(input logic b, output logic r);
		sda_oe = ~b;
		tick();
		scl = 1'b1;
		tick();
		r = sda;
		scl = 1'b0;
		repeat (2) @(posedge lk);
	endtask

	task automatic start();
		sda_oe = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda_oe = 1'b1;
		tick();
		scl = 1'b0;
		repeat (2) @(posedge lk);
	endtask

	task automatic stop();
		sda_oe = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_oe = 1'b0;
		tick();
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack_n);
	endtask

	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

/* File: testbench/rdc_redriver_ctl_asserts.sv */
// Purpose: Port checks of the redriver control block
// Assumes: rst synchronous, active high; windows allow for 3-flop input synchronisers
// Notes: Checks link power, pad drive and output-config safety
module rdc_redriver_ctl_asserts
	import rdc_pkg::*;
#(
	parameter int U1_IDLE_CYCLES = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Inputs and data pad enable watched
	input wire logic sda_oe,
	input wire logic scl_clk,
	input wire logic sleep_input_n,
	input rdc_pkg::rdc_phy_in_s phy_status,
	// Outputs watched
	input rdc_pkg::rdc_phy_ctl_s phy_ctl,
	input rdc_pkg::rdc_mode_s mode,
	input rdc_pkg::rdc_lpm_e link_state,
	input wire logic [3:0] vod_dcgain_sel,
	input wire logic vod_cfg_reserved
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	int u1_cnt_q;

	// Cycles spent in U1; a stuck exit timer would let this grow without end
	always_ff @(posedge mclk) begin
		if (rst || link_state != LPM_U1)
			u1_cnt_q <= 0;
		else
			u1_cnt_q <= u1_cnt_q + 1;
	end

	// ----------------
	// Link conditions
	// ----------------
	sequence s_wake;
		link_state == LPM_DISCONNECT && sleep_input_n && phy_status.term_up && phy_status.term_dn && mode.usb_en;
	endsequence
	sequence s_quiet;
		link_state == LPM_U0 && phy_status.idle_up && phy_status.idle_dn && mode.usb_en;
	endsequence
	sequence s_signal;
		link_state == LPM_U23 && sleep_input_n && phy_status.lfps && phy_status.term_up && phy_status.term_dn
			&& mode.usb_en;
	endsequence

	a_disc_wake: assert property (s_wake [*6] |-> ##[0:3] link_state == LPM_U0) else $error("no wake");
	a_idle_u1: assert property (s_quiet [*6] |-> ##[0:3] link_state == LPM_U1) else $error("no U1");
	a_lfps_u0: assert property (s_signal [*6] |-> ##[0:3] link_state == LPM_U0) else $error("no lfps exit");
	a_sleep_hold: assert property ((!sleep_input_n && link_state == LPM_DISCONNECT) [*6] |=>
		link_state == LPM_DISCONNECT) else $error("left disconnect asleep");
	a_sleep_quiet: assert property (!sleep_input_n [*8] |-> !phy_ctl.rx_detect_en) else $error("detect asleep");
	a_u1_keep: assert property (link_state == LPM_U1 [*2] |-> phy_ctl.rx_term_en && phy_ctl.tx_cm_en)
		else $error("U1 drive");
	a_u23_cm: assert property (link_state == LPM_U23 [*2] |-> phy_ctl.rx_term_en && !phy_ctl.tx_cm_en)
		else $error("U23 drive");
	a_u0_redrive: assert property (link_state == LPM_U0 [*2] |-> phy_ctl.redrive_en) else $error("no redrive");
	a_u1_bound: assert property (u1_cnt_q <= U1_IDLE_CYCLES + 8) else $error("stuck in U1");
	a_usb_off: assert property (!mode.usb_en [*3] |-> link_state == LPM_DISCONNECT) else $error("usb off");
	a_vod_safe: assert property (vod_cfg_reserved |-> vod_dcgain_sel == 4'h0) else $error("reserved vod");
	a_sda_drain: assert property ($changed(sda_oe) |-> !scl_clk) else $error("sda moved, scl high");
endmodule

bind rdc_redriver_ctl rdc_redriver_ctl_asserts #(.U1_IDLE_CYCLES(U1_IDLE_CYCLES)) rdc_redriver_ctl_asserts_i (
	.mclk, .rst, .sda_oe, .scl_clk, .sleep_input_n, .phy_status, .phy_ctl, .mode, .link_state, .vod_dcgain_sel,
	.vod_cfg_reserved);

/* File: testbench/rdc_redriver_ctl_tb.sv */
// Purpose: Self-checking bench of the redriver control block
// Assumes: Bus controller model owns the clock and data pins
// Notes: Short idle and detect counts keep the run brief
module rdc_redriver_ctl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rdc_pkg::*;

	// ----------------
	// Signals
	// ----------------
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sleep_input_n = 1'b1;
	logic [1:0] conn_pins = 2'b11;
	logic orient_pin = 1'b1;
	logic [6:0] snoop = 7'h00;
	rdc_strap_s straps = '0;
	rdc_phy_in_s phy = '0;
	wire scl;
	wire host_oe;
	wire sda_o;
	wire sda_oe;
	wire sda = !(host_oe || sda_oe); // Pulled up unless someone pulls low
	rdc_phy_ctl_s phy_ctl;
	rdc_mode_s mode;
	rdc_lpm_e lstate;
	logic [3:0] vod;
	logic vres;
	logic [6:0] taddr;
	logic [7:0] regs [256];
	logic [7:0] ptr;
	logic [6:0] dev;
	logic [6:0] grp [4] = '{7'h44, 7'h20, 7'h10, 7'h0C};
	logic [7:0] d;
	logic ack_n;
	int failures = 0;
	int checks = 0;

	always #10 mclk = ~mclk;

	rdc_redriver_ctl #(.DB_CYCLES(20), .U1_IDLE_CYCLES(8), .RXDET_CYCLES(16)) rdc_redriver_ctl_i (
		.mclk(mclk), .rst(rst), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .strap_pins(straps),
		.connection_control_pins(conn_pins), .orientation_pin(orient_pin), .sleep_input_n(sleep_input_n),
		.phy_status(phy), .snooped_state(snoop), .phy_ctl(phy_ctl), .mode(mode), .link_state(lstate),
		.vod_dcgain_sel(vod), .vod_cfg_reserved(vres), .target_address(taddr));
	rdc_i2c_host rdc_i2c_host_i (.scl(scl), .sda_oe(host_oe), .sda(sda));

	// ----------------
	// Model and checks
	// ----------------
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			8'h0A, 8'h0C: return 8'h7F;
			8'h0B: return 8'h0F;
			8'h13: return 8'hBF;
			8'h10, 8'h11, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h23: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		if (a == 8'h12)
			return {1'b0, snoop};
		if (a == 8'h0C && !regs[a][6])
			return {2'b00, straps.output_config_strap_hi, straps.output_config_strap_lo, regs[a][1:0]};
		return regs[a];
	endfunction

	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_state(input rdc_lpm_e s);
		for (int n = 0; n < 300 && lstate !== s; n++)
			@(negedge mclk);
		cmp({6'h00, lstate}, {6'h00, s});
		if (lstate !== s)
			results();
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] q[$]);
		rdc_i2c_host_i.start();
		rdc_i2c_host_i.put_byte({dev, 1'b0}, ack_n);
		cmp({7'h00, ack_n}, 8'h00);
		rdc_i2c_host_i.put_byte(idx, ack_n);
		cmp({7'h00, ack_n}, 8'h00);
		ptr = idx;
		foreach (q[i]) begin
			rdc_i2c_host_i.put_byte(q[i], ack_n);
			cmp({7'h00, ack_n}, 8'h00);
			regs[ptr] = (regs[ptr] & ~wmask(ptr)) | (q[i] & wmask(ptr));
			ptr++;
		end
		rdc_i2c_host_i.stop();
	endtask

	task automatic rd(input int n);
		rdc_i2c_host_i.start();
		rdc_i2c_host_i.put_byte({dev, 1'b1}, ack_n);
		cmp({7'h00, ack_n}, 8'h00);
		for (int i = 0; i < n; i++) begin
			rdc_i2c_host_i.get_byte(i == n - 1, d);
			cmp(d, exp_rd(ptr));
			ptr++;
		end
		rdc_i2c_host_i.stop();
	endtask

	// ----------------
	// Sequence
	// ----------------
	initial begin
		rdc_strap_s s;
		logic [7:0] v;
		void'($urandom(32'hFAD765F7));
		// Three power-good releases with fresh straps; the last leaves a legal output config
		for (int r = 0; r < 3; r++) begin
			s = 13'($urandom);
			s.i2c_mode = r != 1;
			if (r == 0)
				s.output_config_strap_hi = 2'b10;
			if (r == 2)
				s.output_config_strap_hi[1] = 1'b0;
			@(posedge mclk);
			rst <= 1'b1;
			straps <= s;
			snoop <= 7'($urandom);
			repeat (10) @(posedge mclk);
			rst <= 1'b0;
			repeat (40) @(negedge mclk);
			dev = grp[s.address_strap_hi] | {5'h00, s.address_strap_lo};
			cmp({1'b0, taddr}, {1'b0, dev});
			v = s.output_config_strap_hi[1] ? 8'h10 : {4'h0, s.output_config_strap_hi, s.output_config_strap_lo};
			cmp({3'h0, vres, vod}, v);
			cmp({1'b0, mode}, r == 1 ? 8'h68 : 8'h40);
		end
		foreach (regs[i])
			regs[i] = 8'h00;
		regs[8'h0A] = 8'h01;
		ptr = 8'h00;
		$display("test straps done");
		rd(13);
		rdc_i2c_host_i.start();
		rdc_i2c_host_i.put_byte({dev ^ 7'h01, 1'b0}, ack_n);
		cmp({7'h00, ack_n}, 8'h01);
		rdc_i2c_host_i.stop();
		wr(8'h0B, '{8'($urandom), 8'($urandom) | 8'h40});
		wr(8'h0B, '{});
		rd(6);
		wr(8'h12, '{8'($urandom)});
		wr(8'h12, '{});
		rd(1);
		rd(2);
		$display("test registers done");
		// Every connection-control code with random neighbouring fields
		for (int c = 0; c < 4; c++) begin
			v = (8'($urandom) & 8'hFC) | 8'(c);
			wr(8'h0A, '{v});
			repeat (4) @(negedge mclk);
			cmp({1'b0, mode}, {1'b0, v[0], v[1], v[1:0] == 2'b10, v[2], v[5], v[4], v[3]});
		end
		$display("test modes done");
		@(posedge mclk);
		sleep_input_n <= 1'b0;
		phy.term_up <= 1'b1;
		phy.term_dn <= 1'b1;
		repeat (40) @(negedge mclk);
		cmp({6'h00, lstate}, {6'h00, LPM_DISCONNECT});
		@(posedge mclk);
		sleep_input_n <= 1'b1;
		wait_state(LPM_U0);
		@(posedge mclk);
		phy.idle_up <= 1'b1;
		phy.idle_dn <= 1'b1;
		wait_state(LPM_U1);
		@(posedge mclk);
		phy.idle_dn <= 1'b0;
		wait_state(LPM_U0);
		@(posedge mclk);
		phy.idle_dn <= 1'b1;
		wait_state(LPM_U1);
		wait_state(LPM_U23);
		@(posedge mclk);
		phy.lfps <= 1'b1;
		wait_state(LPM_U0);
		@(posedge mclk);
		phy.lfps <= 1'b0;
		wait_state(LPM_U23);
		@(posedge mclk);
		phy.term_up <= 1'b0;
		wait_state(LPM_DISCONNECT);
		@(posedge mclk);
		phy.term_up <= 1'b1;
		phy.idle_up <= 1'b0;
		wait_state(LPM_U0);
		wr(8'h0A, '{8'h00});
		wait_state(LPM_DISCONNECT);
		$display("test link power done");
		results();
	end
endmodule
